//--- src/csr_pkg.sv
// Purpose: shared constants and types of the core special-function register block
// Assumes: 8-bit special-function registers, one clock, active-low asynchronous reset
// Notes: register offsets are indices; the byte address on the bus is four times the index
package csr_pkg;

	// ----------------------------------------------------------------
	// register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] SFR_STACK_TOP_PTR = 8'h81;
	localparam logic [7:0] SFR_INDIRECT_PTR_LOW = 8'h82;
	localparam logic [7:0] SFR_INDIRECT_PTR_HIGH = 8'h83;
	localparam logic [7:0] SFR_CORE_STATUS_FLAGS = 8'hd0;
	localparam logic [7:0] SFR_ARITH_MAIN_REG = 8'he0;
	localparam logic [7:0] SFR_AUX_OPERAND_REG = 8'hf0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] STACK_TOP_PTR_RESET = 8'h07;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// ----------------------------------------------------------------
	// status word fields
	// ----------------------------------------------------------------
	localparam int STATUS_CARRY = 7;
	localparam int STATUS_HALF_CARRY = 6;
	localparam int STATUS_USER_ZERO = 5;
	localparam int STATUS_BANK_HI = 4;
	localparam int STATUS_BANK_LO = 3;
	localparam int STATUS_EXCESS = 2;
	localparam int STATUS_USER_ONE = 1;
	localparam int STATUS_PARITY = 0;

	// ----------------------------------------------------------------
	// widths and limits
	// ----------------------------------------------------------------
	localparam int BANK_W = 2;
	localparam int REG_SEL_W = 3;
	localparam int BIT_IDX_W = 3;
	localparam int WB_IDX_LSB = 2;
	localparam int BYTE_MAX = 255;
	localparam int NIBBLE_MAX = 15;

	typedef enum logic [2:0] {
		CSR_OP_ADD,
		CSR_OP_ADDC,
		CSR_OP_SUBB,
		CSR_OP_MUL,
		CSR_OP_DIV
	} csr_op_t;

endpackage : csr_pkg

//--- src/csr_arith.sv
// Purpose: arithmetic and flag generation for the accumulator and the aux operand register
// Assumes: purely combinational; the caller registers every result
// Notes: multiply and divide take the aux operand register as second operand
`timescale 1ns/10ps
module csr_arith import csr_pkg::*; (
	input wire csr_op_t op,
	input wire logic [7:0] acc,
	input wire logic [7:0] aux,
	input wire logic [7:0] src,
	input wire logic carry_in,
	output logic [7:0] acc_res,
	output logic [7:0] aux_res,
	output logic aux_we,
	output logic carry,
	output logic half_carry,
	output logic excess
);
	logic [8:0] wide;
	logic [4:0] nib;
	logic [15:0] prod;
	logic cin;

	always_comb begin
		cin = (op == CSR_OP_ADD) ? 1'b0 : carry_in;
		wide = 9'h000;
		nib = 5'h00;
		prod = 16'h0000;
		acc_res = acc;
		aux_res = aux;
		aux_we = 1'b0;
		carry = 1'b0;
		half_carry = 1'b0;
		excess = 1'b0;
		case (op)
			CSR_OP_ADD, CSR_OP_ADDC: begin
				wide = {1'b0, acc} + {1'b0, src} + {8'h00, cin};
				nib = {1'b0, acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
				acc_res = wide[7:0];
				carry = wide[8];
				half_carry = nib[4];
				excess = (acc[7] == src[7]) && (wide[7] != acc[7]);
			end
			CSR_OP_SUBB: begin
				wide = {1'b0, acc} - {1'b0, src} - {8'h00, cin};
				nib = {1'b0, acc[3:0]} - {1'b0, src[3:0]} - {4'h0, cin};
				acc_res = wide[7:0];
				carry = wide[8];
				half_carry = nib[4];
				excess = (acc[7] != src[7]) && (wide[7] != acc[7]);
			end
			CSR_OP_MUL: begin
				prod = {8'h00, acc} * {8'h00, aux};
				acc_res = prod[7:0];
				aux_res = prod[15:8];
				aux_we = 1'b1;
				excess = (prod[15:8] != 8'h00);
			end
			CSR_OP_DIV: begin
				if (aux == 8'h00) begin
					excess = 1'b1;
				end else begin
					acc_res = acc / aux;
					aux_res = acc % aux;
					aux_we = 1'b1;
				end
			end
			default: begin
				acc_res = acc;
			end
		endcase
	end

endmodule : csr_arith

//--- src/csr_regs.sv
// Purpose: core special-function registers with a classic wishbone slave and a core execution port
// Assumes: one clock; core strobes are one-cycle pulses synchronous to clk
// Notes: per register, alu result beats core bit write beats core byte write beats bus write
`timescale 1ns/10ps

module csr_regs import csr_pkg::*; #(
	parameter int ADR_W = 10
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic op_valid,
	input wire csr_op_t op_code,
	input wire logic [7:0] op_src,
	input wire logic push_req,
	input wire logic pop_req,
	input wire logic core_wr_en,
	input wire logic [7:0] core_wr_addr,
	input wire logic [7:0] core_wr_data,
	input wire logic bit_wr_en,
	input wire logic [7:0] bit_wr_addr,
	input wire logic bit_wr_val,
	input wire logic [REG_SEL_W-1:0] work_reg_sel,
	output logic [7:0] work_reg_addr,
	output logic [15:0] indirect_pointer16,
	output logic push_we,
	output logic [7:0] push_addr,
	output logic [7:0] stack_top_ptr,
	output logic [7:0] arith_main_reg,
	output logic [7:0] aux_operand_reg,
	output logic [7:0] core_status_flags
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic bit_hit(input logic [7:0] baddr, input logic [7:0] base);
		bit_hit = (baddr[7:BIT_IDX_W] == base[7:BIT_IDX_W]);
	endfunction : bit_hit

	function automatic logic [7:0] byte_upd(input logic [7:0] old, input logic bus_we,
		input logic [7:0] bus_d, input logic core_we, input logic [7:0] core_d,
		input logic bit_we, input logic [BIT_IDX_W-1:0] idx, input logic bval);
		logic [7:0] v;
		v = old;
		if (bus_we) begin
			v = bus_d;
		end
		if (core_we) begin
			v = core_d;
		end
		if (bit_we) begin
			v[idx] = bval;
		end
		byte_upd = v;
	endfunction : byte_upd

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] sp_q;
	logic [7:0] dpl_q;
	logic [7:0] dph_q;
	logic [7:0] psw_q;
	logic [7:0] acc_q;
	logic [7:0] b_q;
	logic ack_q;
	logic [31:0] rdat_q;
	logic push_we_q;
	logic [7:0] push_addr_q;
	logic first_q;

	logic [7:0] bus_idx;
	logic bus_wr;
	logic [7:0] bus_wd;
	logic [BIT_IDX_W-1:0] bit_idx;
	logic parity;
	logic [7:0] psw_rd;
	logic [7:0] alu_acc;
	logic [7:0] alu_aux;
	logic alu_aux_we;
	logic alu_cy;
	logic alu_ac;
	logic alu_ov;

	assign bus_idx = wb_adr_i[WB_IDX_LSB +: 8];
	assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
	assign bus_wd = wb_dat_i[7:0];
	assign bit_idx = bit_wr_addr[BIT_IDX_W-1:0];
	assign parity = ^acc_q;
	assign psw_rd = {psw_q[7:1], parity};

	// ----------------------------------------------------------------
	// arithmetic unit
	// ----------------------------------------------------------------
	csr_arith u_arith (
		.op(op_code),
		.acc(acc_q),
		.aux(b_q),
		.src(op_src),
		.carry_in(psw_q[STATUS_CARRY]),
		.acc_res(alu_acc),
		.aux_res(alu_aux),
		.aux_we(alu_aux_we),
		.carry(alu_cy),
		.half_carry(alu_ac),
		.excess(alu_ov)
	);

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdat_q <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
			case (bus_idx)
				SFR_STACK_TOP_PTR: rdat_q <= {24'h00_0000, sp_q};
				SFR_INDIRECT_PTR_LOW: rdat_q <= {24'h00_0000, dpl_q};
				SFR_INDIRECT_PTR_HIGH: rdat_q <= {24'h00_0000, dph_q};
				SFR_CORE_STATUS_FLAGS: rdat_q <= {24'h00_0000, psw_rd};
				SFR_ARITH_MAIN_REG: rdat_q <= {24'h00_0000, acc_q};
				SFR_AUX_OPERAND_REG: rdat_q <= {24'h00_0000, b_q};
				default: rdat_q <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ----------------------------------------------------------------
	// stack pointer and push port
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sp_q <= STACK_TOP_PTR_RESET;
		end else if (push_req) begin
			sp_q <= sp_q + 8'h01;
		end else if (pop_req) begin
			sp_q <= sp_q - 8'h01;
		end else begin
			sp_q <= byte_upd(sp_q, bus_wr && bus_idx == SFR_STACK_TOP_PTR, bus_wd,
				core_wr_en && core_wr_addr == SFR_STACK_TOP_PTR, core_wr_data, 1'b0, bit_idx, 1'b0);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			push_we_q <= 1'b0;
			push_addr_q <= BYTE_RESET;
		end else begin
			push_we_q <= push_req;
			if (push_req) begin
				push_addr_q <= sp_q + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// indirect pointer bytes
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dpl_q <= BYTE_RESET;
		end else begin
			dpl_q <= byte_upd(dpl_q, bus_wr && bus_idx == SFR_INDIRECT_PTR_LOW, bus_wd,
				core_wr_en && core_wr_addr == SFR_INDIRECT_PTR_LOW, core_wr_data, 1'b0, bit_idx, 1'b0);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dph_q <= BYTE_RESET;
		end else begin
			dph_q <= byte_upd(dph_q, bus_wr && bus_idx == SFR_INDIRECT_PTR_HIGH, bus_wd,
				core_wr_en && core_wr_addr == SFR_INDIRECT_PTR_HIGH, core_wr_data, 1'b0, bit_idx, 1'b0);
		end
	end

	// ----------------------------------------------------------------
	// status word
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			psw_q <= BYTE_RESET;
		end else begin
			psw_q <= byte_upd(psw_q, bus_wr && bus_idx == SFR_CORE_STATUS_FLAGS, bus_wd,
				core_wr_en && core_wr_addr == SFR_CORE_STATUS_FLAGS, core_wr_data,
				bit_wr_en && bit_hit(bit_wr_addr, SFR_CORE_STATUS_FLAGS), bit_idx, bit_wr_val);
			psw_q[STATUS_PARITY] <= 1'b0;
			if (op_valid) begin
				psw_q[STATUS_CARRY] <= alu_cy;
				psw_q[STATUS_HALF_CARRY] <= alu_ac;
				psw_q[STATUS_EXCESS] <= alu_ov;
			end
		end
	end

	// ----------------------------------------------------------------
	// accumulator and aux operand register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_q <= BYTE_RESET;
		end else if (op_valid) begin
			acc_q <= alu_acc;
		end else begin
			acc_q <= byte_upd(acc_q, bus_wr && bus_idx == SFR_ARITH_MAIN_REG, bus_wd,
				core_wr_en && core_wr_addr == SFR_ARITH_MAIN_REG, core_wr_data,
				bit_wr_en && bit_hit(bit_wr_addr, SFR_ARITH_MAIN_REG), bit_idx, bit_wr_val);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			b_q <= BYTE_RESET;
		end else if (op_valid && alu_aux_we) begin
			b_q <= alu_aux;
		end else begin
			b_q <= byte_upd(b_q, bus_wr && bus_idx == SFR_AUX_OPERAND_REG, bus_wd,
				core_wr_en && core_wr_addr == SFR_AUX_OPERAND_REG, core_wr_data,
				bit_wr_en && bit_hit(bit_wr_addr, SFR_AUX_OPERAND_REG), bit_idx, bit_wr_val);
		end
	end

	// ----------------------------------------------------------------
	// core-facing outputs
	// ----------------------------------------------------------------
	assign indirect_pointer16 = {dph_q, dpl_q};
	assign work_reg_addr = {{(8 - BANK_W - REG_SEL_W){1'b0}}, psw_q[STATUS_BANK_HI:STATUS_BANK_LO], work_reg_sel};
	assign push_we = push_we_q;
	assign push_addr = push_addr_q;
	assign stack_top_ptr = sp_q;
	assign arith_main_reg = acc_q;
	assign aux_operand_reg = b_q;
	assign core_status_flags = psw_rd;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_push_asked;
		push_req;
	endsequence

	sequence s_push_written;
		push_we && (push_addr == sp_q) && (sp_q == $past(sp_q) + 8'h01);
	endsequence

	a_push_order: assert property (s_push_asked |=> s_push_written) else $error("push not pre-incremented");

	a_sp_reset: assert property (first_q |-> sp_q == STACK_TOP_PTR_RESET) else $error("stack pointer reset wrong");

	a_ptr_bytes: assert property (indirect_pointer16[7:0] == dpl_q && indirect_pointer16[15:8] == dph_q)
		else $error("indirect pointer byte mismatch");

	a_ptr_high_addr: assert property (bus_wr && bus_idx == SFR_INDIRECT_PTR_HIGH && !core_wr_en
		|=> indirect_pointer16[15:8] == $past(bus_wd)) else $error("high pointer write lost");

	a_carry_add: assert property (op_valid && op_code == CSR_OP_ADD
		|=> psw_q[STATUS_CARRY] == (({1'b0, $past(acc_q)} + {1'b0, $past(op_src)}) > BYTE_MAX))
		else $error("carry after add wrong");

	a_half_carry_add: assert property (op_valid && op_code == CSR_OP_ADD
		|=> psw_q[STATUS_HALF_CARRY] == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(op_src[3:0])}) > NIBBLE_MAX))
		else $error("half carry after add wrong");

	a_user_flags_hold: assert property (!bit_wr_en && !core_wr_en && !bus_wr
		|=> $stable(psw_q[STATUS_USER_ZERO]) && $stable(psw_q[STATUS_USER_ONE])) else $error("user flag changed");

	a_bank_map: assert property (work_reg_addr == {3'b000, psw_q[STATUS_BANK_HI:STATUS_BANK_LO], work_reg_sel})
		else $error("bank mapping wrong");

	a_mul_excess: assert property (op_valid && op_code == CSR_OP_MUL
		|=> psw_q[STATUS_EXCESS] == (({8'h00, $past(acc_q)} * {8'h00, $past(b_q)}) > BYTE_MAX))
		else $error("multiply overflow flag wrong");

	a_div_clear: assert property (op_valid && op_code == CSR_OP_DIV && b_q != 8'h00
		|=> !psw_q[STATUS_EXCESS] && !psw_q[STATUS_CARRY]) else $error("divide flags not cleared");

	a_parity_live: assert property (core_status_flags[STATUS_PARITY] == ^arith_main_reg)
		else $error("parity flag wrong");

	a_mul_high: assert property (op_valid && op_code == CSR_OP_MUL
		|=> {b_q, acc_q} == {8'h00, $past(acc_q)} * {8'h00, $past(b_q)}) else $error("product not split");

	a_reset_clear: assert property (first_q |-> dpl_q == BYTE_RESET && dph_q == BYTE_RESET
		&& psw_q == BYTE_RESET && acc_q == BYTE_RESET && b_q == BYTE_RESET) else $error("reset values wrong");

	// ----------------------------------------------------------------
	// further flag, bus and push checks
	// ----------------------------------------------------------------
	a_carry_subb: assert property (op_valid && op_code == CSR_OP_SUBB
		|=> psw_q[STATUS_CARRY] == ({1'b0, $past(acc_q)} < ({1'b0, $past(op_src)} + {8'h00, $past(psw_q[STATUS_CARRY])})))
		else $error("borrow after subtract wrong");

	a_mul_flags_clear: assert property (op_valid && op_code == CSR_OP_MUL
		|=> !psw_q[STATUS_CARRY] && !psw_q[STATUS_HALF_CARRY]) else $error("multiply carries not cleared");

	a_add_excess: assert property (op_valid && op_code == CSR_OP_ADD
		|=> psw_q[STATUS_EXCESS] == (($past(acc_q[7]) == $past(op_src[7])) && (acc_q[7] != $past(acc_q[7]))))
		else $error("signed overflow after add wrong");

	a_div_zero: assert property (op_valid && op_code == CSR_OP_DIV && b_q == 8'h00
		|=> psw_q[STATUS_EXCESS] && $stable(acc_q) && $stable(b_q)) else $error("divide by zero handling wrong");

	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");

	a_ptr_out: assert property (push_req |=> stack_top_ptr == push_addr)
		else $error("push address differs from pointer");

endmodule : csr_regs

//--- testbench/csr_regs_tb.sv
// Purpose: self-checking bench of the core special-function register block
// Assumes: classic wishbone single cycles, core strobes are one-cycle pulses except push_req, held for two cycles to push twice
// Notes: expected values are worked out here from register and flag behaviour
`timescale 1ns/10ps
module csr_regs_tb import csr_pkg::*;;
	// ----------------------------------------------------------------
	// signals and design
	// ----------------------------------------------------------------
	logic clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, op_valid, push_req, pop_req;
	logic core_wr_en, bit_wr_en, bit_wr_val, push_we;
	logic [9:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	csr_op_t op_code;
	logic [7:0] op_src, core_wr_addr, core_wr_data, bit_wr_addr, work_reg_addr, push_addr;
	logic [7:0] stack_top_ptr, arith_main_reg, aux_operand_reg, core_status_flags;
	logic [2:0] work_reg_sel;
	logic [15:0] indirect_pointer16;
	int miscompares, tests_run;
	localparam logic [7:0] R_IDX [7] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0, 8'h84};
	localparam logic [7:0] R_EXP [7] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam csr_op_t T_OP [8] = '{CSR_OP_ADD, CSR_OP_ADD, CSR_OP_ADDC, CSR_OP_SUBB,
		CSR_OP_MUL, CSR_OP_MUL, CSR_OP_DIV, CSR_OP_DIV};
	localparam logic [7:0] T_SRC [8] = '{8'h01, 8'h80, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] T_ACC [8] = '{8'h7f, 8'h80, 8'h00, 8'h01, 8'h10, 8'h03, 8'h09, 8'h09};
	localparam logic [7:0] T_AUX [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h04, 8'h02, 8'h00};
	localparam logic [7:0] E_ACC [8] = '{8'h80, 8'h00, 8'h01, 8'hff, 8'h00, 8'h0c, 8'h04, 8'h09};
	localparam logic [7:0] E_AUX [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00};
	localparam logic [2:0] E_FLG [8] = '{3'h3, 3'h5, 3'h0, 3'h6, 3'h1, 3'h0, 3'h0, 3'h1};

	csr_regs #(.ADR_W(10)) uut (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .op_valid(op_valid), .op_code(op_code),
		.op_src(op_src), .push_req(push_req), .pop_req(pop_req), .core_wr_en(core_wr_en),
		.core_wr_addr(core_wr_addr), .core_wr_data(core_wr_data), .bit_wr_en(bit_wr_en),
		.bit_wr_addr(bit_wr_addr), .bit_wr_val(bit_wr_val), .work_reg_sel(work_reg_sel),
		.work_reg_addr(work_reg_addr), .indirect_pointer16(indirect_pointer16), .push_we(push_we),
		.push_addr(push_addr), .stack_top_ptr(stack_top_ptr), .arith_main_reg(arith_main_reg),
		.aux_operand_reg(aux_operand_reg), .core_status_flags(core_status_flags));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task results;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	task bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
		int n;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			miscompares++;
			results();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : bus

	task op(input csr_op_t c, input logic [7:0] s);
		@(posedge clk);
		op_valid <= 1'b1;
		op_code <= c;
		op_src <= s;
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
	endtask : op

	task bitw(input logic [7:0] a, input logic v);
		@(posedge clk);
		bit_wr_en <= 1'b1;
		bit_wr_addr <= a;
		bit_wr_val <= v;
		@(posedge clk);
		bit_wr_en <= 1'b0;
		#1;
	endtask : bitw

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		results();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{rstn, wb_cyc_i, wb_stb_i, wb_we_i, op_valid, push_req, pop_req} = '0;
		{core_wr_en, bit_wr_en, bit_wr_val, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		{op_src, core_wr_addr, core_wr_data, bit_wr_addr, work_reg_sel} = '0;
		op_code = CSR_OP_ADD;
		miscompares = 0;
		tests_run = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, R_IDX[i], 8'h00);
			check("reset read", {24'h0, R_EXP[i]}, rd);
		end
		bus(1'b1, 8'h82, 8'h34);
		bus(1'b1, 8'h83, 8'h12);
		check("pointer16", 32'h1234, {16'h0, indirect_pointer16});
		bus(1'b0, 8'h83, 8'h00);
		check("high byte read", 32'h12, rd);
		@(posedge clk);
		push_req <= 1'b1;
		@(posedge clk);
		#1;
		check("push ptr", 32'h11, {23'h0, stack_top_ptr, push_we});
		check("push addr", 32'h08, {24'h0, push_addr});
		@(posedge clk);
		push_req <= 1'b0;
		pop_req <= 1'b1;
		core_wr_en <= 1'b1;
		core_wr_addr <= 8'h82;
		core_wr_data <= 8'h56;
		#1;
		check("push2 addr", 32'h1_09_09, {15'h0, push_we, push_addr, stack_top_ptr});
		@(posedge clk);
		{pop_req, core_wr_en} <= 2'b00;
		#1;
		check("pop ptr", 32'h08, {24'h0, stack_top_ptr});
		check("core low byte", 32'h1256, {16'h0, indirect_pointer16});
		for (int b = 0; b < 4; b++) begin
			work_reg_sel <= 3'(2 * b + 1);
			bus(1'b1, 8'hd0, 8'h22 | 8'(b << 3));
			#1;
			check("bank addr", {24'h0, 3'b000, 2'(b), 3'(2 * b + 1)}, {24'h0, work_reg_addr});
		end
		bus(1'b1, 8'hd0, 8'h23);
		bus(1'b0, 8'hd0, 8'h00);
		check("status read", 32'h22, rd);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, 8'he0, T_ACC[i]);
			bus(1'b1, 8'hf0, T_AUX[i]);
			op(T_OP[i], T_SRC[i]);
			check("acc result", {24'h0, E_ACC[i]}, {24'h0, arith_main_reg});
			check("aux result", {24'h0, E_AUX[i]}, {24'h0, aux_operand_reg});
			check("cy ac ov", {29'h0, E_FLG[i]}, {29'h0, core_status_flags[7:6], core_status_flags[2]});
			check("parity", {31'h0, ^E_ACC[i]}, {31'h0, core_status_flags[0]});
			check("user flags", 32'h22, {24'h0, core_status_flags & 8'h3a});
		end
		bitw(8'hd5, 1'b0);
		check("bit clear f", 32'h02, {24'h0, core_status_flags & 8'h3a});
		bitw(8'he7, 1'b1);
		check("acc bit set", 32'h189, {23'h0, core_status_flags[0], arith_main_reg});
		bitw(8'hf4, 1'b1);
		check("aux bit set", 32'h10, {24'h0, aux_operand_reg});
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		bus(1'b0, 8'h81, 8'h00);
		check("re-reset ptr", 32'h07, rd);
		bus(1'b0, 8'he0, 8'h00);
		check("re-reset acc", 32'h00, rd);
		results();
	end
endmodule : csr_regs_tb
